// ===== mcu_regs_pkg.sv
// Constants, register indices and types for the operational register file.
package mcu_regs_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int unsigned PCLK_NS = 10;
	localparam int unsigned INSTR_NS = 20;
	localparam int unsigned PCLK_PER_INSTR = (INSTR_NS + PCLK_NS - 1) / PCLK_NS;
	localparam logic [3:0] WAIT_PLAIN = 4'(PCLK_PER_INSTR);
	localparam logic [3:0] WAIT_PCMOD = 4'(2 * PCLK_PER_INSTR);

	// ----------------------------------------------------------------
	// Register indices, byte address is four times the index
	// ----------------------------------------------------------------
	localparam logic [6:0] IDX_INDIRECT = 7'h00;
	localparam logic [6:0] IDX_TIMER = 7'h01;
	localparam logic [6:0] IDX_PC = 7'h02;
	localparam logic [6:0] IDX_STATUS = 7'h03;
	localparam logic [6:0] IDX_RAMSEL = 7'h04;
	localparam logic [6:0] IDX_PORTA = 7'h05;
	localparam logic [6:0] IDX_PORTB = 7'h06;
	localparam logic [6:0] IDX_IRQ = 7'h0F;
	localparam logic [6:0] IDX_RAM_LO = 7'h10;
	localparam logic [6:0] IDX_RAM_HI = 7'h3F;
	localparam logic [6:0] IDX_CTRL = 7'h40;
	localparam logic [6:0] IDX_MASK = 7'h41;
	localparam logic [6:0] IDX_OP = 7'h42;
	localparam logic [6:0] IDX_PCFULL = 7'h43;

	// ----------------------------------------------------------------
	// Fields and reset values
	// ----------------------------------------------------------------
	localparam int unsigned ST_C = 0;
	localparam int unsigned ST_AUX = 1;
	localparam int unsigned ST_Z = 2;
	localparam int unsigned ST_P = 3;
	localparam int unsigned ST_T = 4;
	localparam logic [7:0] STATUS_RST = 8'h18;
	localparam logic [7:0] STATUS_HW_MASK = 8'h18;
	localparam int unsigned CTL_EDGE_SEL = 4;
	localparam int unsigned CTL_SRC_SEL = 5;
	localparam int unsigned IRQ_TIMER = 0;
	localparam int unsigned IRQ_PORT = 1;
	localparam int unsigned IRQ_EXT = 2;
	localparam int unsigned IRQ_W = 3;
	localparam int unsigned RAMSEL_W = 6;
	localparam int unsigned PORTA_W = 4;
	localparam int unsigned PC_W = 10;
	localparam int unsigned STACK_DEPTH = 5;
	localparam int unsigned RAM_WORDS = 48;
	localparam int unsigned OP_ARG_LSB = 8;
	localparam logic [7:0] BYTE_MAX = 8'hFF;

	// ----------------------------------------------------------------
	// Operation codes written to the operation register
	// ----------------------------------------------------------------
	localparam logic [3:0] OP_JUMP = 4'h1;
	localparam logic [3:0] OP_CALL = 4'h2;
	localparam logic [3:0] OP_RET = 4'h3;
	localparam logic [3:0] OP_RET_LIT = 4'h4;
	localparam logic [3:0] OP_RET_IRQ = 4'h5;
	localparam logic [3:0] OP_ADD_PC = 4'h6;
	localparam logic [3:0] OP_MOV_PC = 4'h7;
	localparam logic [3:0] OP_SLEEP = 4'h8;
	localparam logic [3:0] OP_WDT_CLEAR = 4'h9;
	localparam logic [3:0] OP_WDT_TIMEOUT = 4'hA;

	typedef enum logic [1:0] {BUS_IDLE, BUS_WAIT, BUS_DONE} bus_state_t;

endpackage

// ===== mcu_op_regs.sv
// Operational register file of the small microcontroller core, reached over APB.
//
// Our own choices: register access over APB and the placing of the registers.
`timescale 1ns/10ps
// Behaviour
// - Held reset keeps everything idle
// - Indirect pointer accesses register at ram_select
// - Timer counts pin edges or instruction cycles
// - Timer reads and writes like any register
// - Reset clears the program counter
// - Program counter spans 1024 words
// - Jump loads low ten counter bits
// - Call loads target, pushes next address
// - All returns pop the top stack entry
// - Hardware stack holds five levels
// - Add accumulator to counter as offset
// - Move accumulator into low eight bits
// - Counter writes clear the upper bits
// - Counter modifying access takes extra cycle
// - Instruction cycle is two clock periods
// - Status carry, aux carry, zero bits
// - Power-down flag set, cleared by ops
// - Time-out flag set, cleared by timeout
// - Status top bits are plain storage
// - Ram select low six bits address
// - Port A four bits, B eight
// - Interrupt flags set by three events
// - External interrupt on falling edge
// - Software only clears interrupt flags
// - Flag read is ANDed with mask
// - Port B change wakes from sleep
// - Addresses 10 to 3F are RAM
// - Source select picks clock or pin
// - Each source's flag read gated by mask bit, port B wake is not
module mcu_op_regs (
	// Clock, reset and enable
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [8:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Pins
	input wire logic timer_counter_pin,
	input wire logic ext_int_n,
	input wire logic [7:0] port_b_in,
	output logic [mcu_regs_pkg::PORTA_W-1:0] port_a_out,
	output logic [7:0] port_b_out,
	// Core state
	output logic [mcu_regs_pkg::PC_W-1:0] pc_out,
	output logic sleeping
);
	import mcu_regs_pkg::*;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	bus_state_t bus_ff;
	logic [3:0] wait_ff;
	logic pready_ff, pslverr_ff, phase_ff, sleep_ff;
	logic [31:0] prdata_ff;
	logic [7:0] timer_ff, status_ff, ramsel_ff, portb_ff, ctrl_ff;
	logic [PORTA_W-1:0] porta_ff;
	logic [IRQ_W-1:0] irq_ff, mask_ff;
	logic [PC_W-1:0] pc_ff;
	logic [PC_W-1:0] stack_ff [STACK_DEPTH];
	logic [7:0] ram_ff [RAM_WORDS];
	logic tpin_s1, tpin_s2, tpin_s3, ext_s1, ext_s2, ext_s3;
	logic [7:0] pb_s1, pb_s2, pb_s3;

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	wire [6:0] idx = paddr[8:2];
	wire [6:0] idx_eff = (idx == IDX_INDIRECT) ? {1'b0, ramsel_ff[RAMSEL_W-1:0]} : idx;
	wire is_ram = (idx_eff >= IDX_RAM_LO) && (idx_eff <= IDX_RAM_HI);
	wire [5:0] ram_idx = 6'(idx_eff - IDX_RAM_LO);
	// Indirect reach of 07..0E or of itself lands on nothing and reads zero.
	wire dead_ind = (idx == IDX_INDIRECT) && !is_ram && ((idx_eff > IDX_PORTB) && (idx_eff != IDX_IRQ)
		|| (idx_eff == IDX_INDIRECT));
	wire mapped = (paddr[1:0] == 2'b00) && ((idx <= IDX_PORTB) || (idx >= IDX_IRQ && idx <= IDX_PCFULL));
	wire fire = psel && penable && (bus_ff == BUS_DONE) && clk_en;
	wire wr = fire && pwrite && mapped && !dead_ind;
	wire wr_timer = wr && (idx_eff == IDX_TIMER);
	wire wr_pc = wr && (idx_eff == IDX_PC);
	wire wr_status = wr && (idx_eff == IDX_STATUS);
	wire wr_irq = wr && (idx_eff == IDX_IRQ);
	wire wr_op = wr && (idx == IDX_OP);
	wire [3:0] op = pwdata[3:0];
	wire [PC_W-1:0] op_arg = pwdata[OP_ARG_LSB +: PC_W];
	wire op_jump = wr_op && (op == OP_JUMP);
	wire op_call = wr_op && (op == OP_CALL);
	wire op_ret = wr_op && (op == OP_RET || op == OP_RET_LIT || op == OP_RET_IRQ);
	wire op_add = wr_op && (op == OP_ADD_PC);
	wire op_mov = wr_op && (op == OP_MOV_PC);
	wire op_sleep = wr_op && (op == OP_SLEEP);
	wire op_watchdog_clear_op = wr_op && (op == OP_WDT_CLEAR);
	wire op_wdto = wr_op && (op == OP_WDT_TIMEOUT);
	wire pw_op = pwdata[3:0] >= OP_JUMP && pwdata[3:0] <= OP_MOV_PC;
	wire pc_mod = pwrite && (idx_eff == IDX_PC || (idx == IDX_OP && pw_op));

	// ----------------------------------------------------------------
	// Read selection
	// ----------------------------------------------------------------
	wire [7:0] rd_byte =
		is_ram ? ram_ff[ram_idx] :
		idx_eff == IDX_TIMER ? timer_ff :
		idx_eff == IDX_PC ? pc_ff[7:0] :
		idx_eff == IDX_STATUS ? status_ff :
		idx_eff == IDX_RAMSEL ? ramsel_ff :
		idx_eff == IDX_PORTA ? {4'h0, porta_ff} :
		idx_eff == IDX_PORTB ? pb_s2 :
		idx_eff == IDX_IRQ ? {5'h00, irq_ff & mask_ff} :
		idx_eff == IDX_CTRL ? ctrl_ff :
		idx_eff == IDX_MASK ? {5'h00, mask_ff} : 8'h00;
	wire [31:0] rd_val = !mapped || dead_ind ? 32'h0000_0000 :
		idx == IDX_PCFULL ? {22'h00_0000, pc_ff} : {24'h00_0000, rd_byte};

	// ----------------------------------------------------------------
	// APB handshake
	// ----------------------------------------------------------------
	// Every access waits out one instruction cycle, and a counter-modifying access two, so that it lines up with the core's own pace.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bus_ff <= BUS_IDLE;
			wait_ff <= 4'h0;
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff <= 32'h0000_0000;
		end else if (clk_en) begin
			case (bus_ff)
				BUS_IDLE: begin
					if (psel && penable) begin
						wait_ff <= pc_mod ? WAIT_PCMOD : WAIT_PLAIN;
						bus_ff <= BUS_WAIT;
					end
				end
				BUS_WAIT: begin
					if (wait_ff == 4'h1) begin
						pready_ff <= 1'b1;
						pslverr_ff <= !mapped;
						prdata_ff <= pwrite ? 32'h0000_0000 : rd_val;
						bus_ff <= BUS_DONE;
					end
					wait_ff <= wait_ff - 4'h1;
				end
				BUS_DONE: begin
					pready_ff <= 1'b0;
					pslverr_ff <= 1'b0;
					bus_ff <= BUS_IDLE;
				end
				default: bus_ff <= BUS_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Pin synchronisers and event detection
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{tpin_s1, tpin_s2, tpin_s3} <= 3'h0;
			{ext_s1, ext_s2, ext_s3} <= 3'h7;
			{pb_s1, pb_s2, pb_s3} <= 24'h00_0000;
		end else if (clk_en) begin
			{tpin_s1, tpin_s2, tpin_s3} <= {timer_counter_pin, tpin_s1, tpin_s2};
			{ext_s1, ext_s2, ext_s3} <= {ext_int_n, ext_s1, ext_s2};
			{pb_s1, pb_s2, pb_s3} <= {port_b_in, pb_s1, pb_s2};
		end
	end
	wire instr_tick = phase_ff;
	// The third stage only remembers the settled level, so that edges can be seen.
	wire t_rise = tpin_s2 && !tpin_s3;
	wire t_fall = !tpin_s2 && tpin_s3;
	wire t_edge = ctrl_ff[CTL_EDGE_SEL] ? t_fall : t_rise;
	wire t_inc = ctrl_ff[CTL_SRC_SEL] ? t_edge : instr_tick;
	wire t_ovf = t_inc && (timer_ff == BYTE_MAX) && !wr_timer;
	wire ext_fall = ext_s3 && !ext_s2;
	wire pb_change = pb_s2 != pb_s3;
	wire [IRQ_W-1:0] irq_set = {ext_fall, pb_change, t_ovf};
	wire [IRQ_W-1:0] irq_keep = wr_irq ? pwdata[IRQ_W-1:0] : {IRQ_W{1'b1}};
	// Carry comes from the low byte only, since the accumulator add is an eight-bit operation.
	wire [8:0] add_sum = {1'b0, pc_ff[7:0]} + {1'b0, pwdata[OP_ARG_LSB +: 8]};
	wire [7:0] add_lo = add_sum[7:0];

	// ----------------------------------------------------------------
	// Timer, ports and controls
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phase_ff <= 1'b0;
			timer_ff <= 8'h00;
			ramsel_ff <= 8'h00;
			porta_ff <= 4'h0;
			portb_ff <= 8'h00;
			ctrl_ff <= 8'h00;
			mask_ff <= 3'h0;
			irq_ff <= 3'h0;
			sleep_ff <= 1'b0;
		end else if (clk_en) begin
			phase_ff <= !phase_ff;
			if (wr_timer)
				timer_ff <= pwdata[7:0];
			else if (t_inc)
				timer_ff <= timer_ff + 8'h01;
			if (wr && idx_eff == IDX_RAMSEL)
				ramsel_ff <= pwdata[7:0];
			if (wr && idx_eff == IDX_PORTA)
				porta_ff <= pwdata[PORTA_W-1:0];
			if (wr && idx_eff == IDX_PORTB)
				portb_ff <= pwdata[7:0];
			if (wr && idx == IDX_CTRL)
				ctrl_ff <= pwdata[7:0];
			if (wr && idx == IDX_MASK)
				mask_ff <= pwdata[IRQ_W-1:0];
			irq_ff <= (irq_ff & irq_keep) | irq_set;
			if (pb_change)
				sleep_ff <= 1'b0;
			else if (op_sleep)
				sleep_ff <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Status register
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_ff <= STATUS_RST;
		end else if (clk_en) begin
			if (wr_status)
				status_ff <= (pwdata[7:0] & ~STATUS_HW_MASK) | (status_ff & STATUS_HW_MASK);
			else if (op_add) begin
				status_ff[ST_Z] <= (add_lo == 8'h00);
				status_ff[ST_C] <= add_sum[8];
			end
			if (op_sleep) begin
				status_ff[ST_P] <= 1'b0;
				status_ff[ST_T] <= 1'b1;
			end else if (op_watchdog_clear_op) begin
				status_ff[ST_P] <= 1'b1;
				status_ff[ST_T] <= 1'b1;
			end else if (op_wdto)
				status_ff[ST_T] <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Program counter and stack
	// ----------------------------------------------------------------
	// Computed jumps drop bits 8 and 9, so they only reach the first 256 words.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pc_ff <= '0;
		end else if (clk_en) begin
			if (op_jump || op_call)
				pc_ff <= op_arg;
			else if (op_ret)
				pc_ff <= stack_ff[0];
			else if (op_add)
				pc_ff <= {2'b00, add_lo};
			else if (op_mov)
				pc_ff <= {2'b00, pwdata[OP_ARG_LSB +: 8]};
			else if (wr_pc)
				pc_ff <= {2'b00, pwdata[7:0]};
		end
	end

	// A sixth nested call pushes the oldest entry out, there is no overflow flag.
	for (genvar i = 0; i < STACK_DEPTH; i++) begin : g_stack
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn)
				stack_ff[i] <= '0;
			else if (clk_en && op_call)
				stack_ff[i] <= (i == 0) ? pc_ff + 10'h001 : stack_ff[(i == 0) ? 0 : i - 1];
			else if (clk_en && op_ret)
				stack_ff[i] <= stack_ff[(i == STACK_DEPTH - 1) ? i : i + 1];
		end
	end

	// ----------------------------------------------------------------
	// General purpose RAM
	// ----------------------------------------------------------------
	always_ff @(posedge pclk) begin
		if (clk_en && wr && is_ram)
			ram_ff[ram_idx] <= pwdata[7:0];
	end

	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;
	assign port_a_out = porta_ff;
	assign port_b_out = portb_ff;
	assign pc_out = pc_ff;
	assign sleeping = sleep_ff;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	a_jump_target: assert property (op_jump |=> pc_ff == $past(op_arg))
		else $error("jump did not load target");
	a_call_push: assert property (op_call |=> stack_ff[0] == $past(pc_ff) + 10'h001)
		else $error("call pushed wrong address");
	a_ret_pop: assert property (op_ret |=> pc_ff == $past(stack_ff[0]) && stack_ff[0] == $past(stack_ff[1]))
		else $error("return did not pop stack");
	a_pc_upper_clear: assert property ((wr_pc || op_mov || op_add) |=> pc_ff[9:8] == 2'b00)
		else $error("upper counter bits not cleared");
	a_pcmod_latency: assert property ((bus_ff == BUS_IDLE && psel && penable && clk_en && pc_mod)
		|=> wait_ff == WAIT_PCMOD)
		else $error("counter access not stretched");
	a_phase_toggle: assert property (clk_en && instr_tick |=> !instr_tick)
		else $error("instruction cycle not two clocks");
	a_timer_count: assert property (clk_en && !ctrl_ff[CTL_SRC_SEL] && instr_tick && !wr_timer
		|=> timer_ff == $past(timer_ff) + 8'h01)
		else $error("timer missed a cycle");
	a_irq_set_wins: assert property (clk_en && |irq_set |=> (irq_ff & $past(irq_set)) == $past(irq_set))
		else $error("flag event lost");
	a_irq_read_mask: assert property ($rose(pready_ff) && !pwrite && idx_eff == IDX_IRQ && mapped
		|-> prdata_ff[2:0] == $past(irq_ff & mask_ff))
		else $error("flag read not masked");
	a_sleep_flags: assert property (op_sleep |=> !status_ff[ST_P] && status_ff[ST_T])
		else $error("sleep flags wrong");
	a_wake_change: assert property (clk_en && pb_change |=> !sleep_ff)
		else $error("port change did not wake");
	a_add_carry: assert property (op_add |=> status_ff[ST_C] == ($past(pc_ff[7:0]) > ~$past(op_arg[7:0])))
		else $error("add carry wrong");
	a_irq_no_set: assert property (wr_irq && !(|irq_set) |=> (irq_ff & ~$past(irq_ff)) == 3'h0)
		else $error("software set a flag");

	c_call_ret: cover property (op_call ##[1:50] op_ret);
	c_timer_ovf: cover property (t_ovf);
	c_sleep_wake: cover property (sleep_ff ##1 !sleep_ff);
	c_ext_irq: cover property (ext_fall && mask_ff[IRQ_EXT]);
	c_pcmod_access: cover property (bus_ff == BUS_IDLE && psel && penable && pc_mod);

endmodule // mcu_op_regs

// ===== tb_top.sv
// Self-checking testbench for the operational register file.
`timescale 1ns/10ps
module tb_top;
	import mcu_regs_pkg::*;
	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic clk_en = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [8:0] paddr = 9'h000;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic timer_counter_pin = 1'b0;
	logic ext_int_n = 1'b1;
	logic [7:0] port_b_in = 8'h00;
	logic [PORTA_W-1:0] port_a_out;
	logic [7:0] port_b_out;
	logic [PC_W-1:0] pc_out;
	logic sleeping;
	int num_errors = 0;
	int compares = 0;
	int cycles = 0;
	int last_wait = 0;
	logic [31:0] rdv;
	logic errv;

	always #5 pclk = ~pclk;

	mcu_op_regs u_dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.timer_counter_pin(timer_counter_pin), .ext_int_n(ext_int_n), .port_b_in(port_b_in),
		.port_a_out(port_a_out), .port_b_out(port_b_out), .pc_out(pc_out), .sleeping(sleeping));

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic wrap_up();
		$display("Checks: %0d, mismatches: %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// The ceiling is many times the expected run, so a stuck pready ends the run.
	always @(posedge pclk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			num_errors++;
			wrap_up();
		end
	end

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			num_errors++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge pclk);
	endtask

	// Request is held until pready is sampled high; read data is taken at that edge.
	task automatic apb(input logic wr, input logic [6:0] idx, input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {idx, 2'b00};
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1);
		rdv = prdata;
		errv = pslverr;
		last_wait = n;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [6:0] idx, input logic [7:0] d);
		apb(1'b1, idx, {24'h000000, d});
	endtask

	task automatic rd(input string name, input logic [6:0] idx, input logic [31:0] exp);
		apb(1'b0, idx, 32'h00000000);
		chk(name, exp, rdv);
		chk("pslverr", 32'h0, {31'h0, errv});
	endtask

	task automatic op(input logic [3:0] code, input logic [9:0] arg);
		apb(1'b1, IDX_OP, {14'h0000, arg, 4'h0, code});
	endtask

	task automatic chk_pc(input logic [PC_W-1:0] exp);
		@(negedge pclk);
		chk("pc_out", {22'h0, exp}, {22'h0, pc_out});
	endtask

	task automatic pulse_pin(input int n);
		repeat (n) begin
			@(posedge pclk) timer_counter_pin <= 1'b1;
			idle(4);
			@(posedge pclk) timer_counter_pin <= 1'b0;
			idle(4);
		end
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reset();
		idle(15);
		@(negedge pclk);
		chk("pready in reset", 32'h0, {31'h0, pready});
		chk("pc in reset", 32'h0, {22'h0, pc_out});
		@(posedge pclk);
		presetn <= 1'b1;
		rd("status reset", IDX_STATUS, {24'h0, STATUS_RST});
		rd("pc reset", IDX_PCFULL, 32'h0);
	endtask

	task automatic t_ram();
		wr(IDX_RAM_LO, 8'hA5);
		wr(IDX_RAM_HI, 8'h3C);
		rd("ram lo", IDX_RAM_LO, 32'hA5);
		rd("ram hi", IDX_RAM_HI, 32'h3C);
		wr(IDX_RAMSEL, 8'hE0);
		wr(IDX_INDIRECT, 8'h5A);
		rd("ram via ptr", 7'h20, 32'h5A);
		rd("ram_select", IDX_RAMSEL, 32'hE0);
		wr(7'h20, 8'h33);
		rd("ptr read", IDX_INDIRECT, 32'h33);
		wr(IDX_RAMSEL, 8'h08);
		rd("ptr hole", IDX_INDIRECT, 32'h0);
		apb(1'b0, 7'h07, 32'h0);
		chk("unmapped err", 32'h1, {31'h0, errv});
		chk("unmapped data", 32'h0, rdv);
	endtask

	task automatic t_status();
		wr(IDX_STATUS, 8'hE0);
		rd("status spare", IDX_STATUS, 32'hF8);
		wr(IDX_STATUS, 8'h00);
		op(OP_SLEEP, 10'h000);
		rd("status sleep", IDX_STATUS, 32'h10);
		chk("sleeping", 32'h1, {31'h0, sleeping});
		@(posedge pclk) port_b_in <= 8'h01;
		idle(6);
		chk("wake", 32'h0, {31'h0, sleeping});
		op(OP_WDT_CLEAR, 10'h000);
		rd("status wdt clear", IDX_STATUS, 32'h18);
		op(OP_WDT_TIMEOUT, 10'h000);
		rd("status timeout", IDX_STATUS, 32'h08);
	endtask

	task automatic t_ports();
		wr(IDX_PORTA, 8'hFF);
		rd("port a", IDX_PORTA, 32'h0F);
		wr(IDX_PORTB, 8'hA5);
		@(negedge pclk);
		chk("port a pins", 32'hF, {28'h0, port_a_out});
		chk("port b pins", 32'hA5, {24'h0, port_b_out});
		@(posedge pclk) port_b_in <= 8'h3C;
		idle(4);
		rd("port b in", IDX_PORTB, 32'h3C);
	endtask

	task automatic t_pc();
		int plain;
		wr(IDX_RAM_LO, 8'h11);
		plain = last_wait;
		op(OP_JUMP, 10'h3FF);
		chk("extra cycle", 32'(WAIT_PCMOD - WAIT_PLAIN), 32'(last_wait - plain));
		chk_pc(10'h3FF);
		wr(IDX_PC, 8'h80);
		chk_pc(10'h080);
		op(OP_JUMP, 10'h3F0);
		op(OP_ADD_PC, 10'h005);
		chk_pc(10'h0F5);
		op(OP_JUMP, 10'h3FB);
		op(OP_ADD_PC, 10'h005);
		chk_pc(10'h000);
		rd("carry zero", IDX_STATUS, 32'h0D);
		op(OP_JUMP, 10'h2C0);
		op(OP_MOV_PC, 10'h077);
		chk_pc(10'h077);
		rd("pc low", IDX_PC, 32'h77);
	endtask

	task automatic t_stack();
		logic [3:0] rets [5];
		logic [9:0] exp [5];
		rets = '{OP_RET, OP_RET_LIT, OP_RET_IRQ, OP_RET, OP_RET};
		exp = '{10'h204, 10'h203, 10'h202, 10'h201, 10'h101};
		op(OP_JUMP, 10'h100);
		for (int i = 0; i < 5; i++) begin
			op(OP_CALL, 10'(10'h200 + i));
			chk_pc(10'(10'h200 + i));
		end
		for (int i = 0; i < 5; i++) begin
			op(rets[i], 10'h000);
			chk_pc(exp[i]);
		end
	endtask

	task automatic t_timer();
		wr(IDX_CTRL, 8'h20);
		wr(IDX_TIMER, 8'h5A);
		rd("timer rw", IDX_TIMER, 32'h5A);
		wr(IDX_TIMER, 8'h00);
		pulse_pin(5);
		rd("timer rise", IDX_TIMER, 32'h05);
		wr(IDX_CTRL, 8'h30);
		wr(IDX_TIMER, 8'h00);
		pulse_pin(3);
		rd("timer fall", IDX_TIMER, 32'h03);
		wr(IDX_MASK, 8'h07);
		wr(IDX_IRQ, 8'h00);
		wr(IDX_CTRL, 8'h00);
		wr(IDX_TIMER, 8'hFE);
		idle(10);
		wr(IDX_CTRL, 8'h20);
		rd("overflow", IDX_IRQ, 32'h01);
		wr(IDX_TIMER, 8'h00);
		@(posedge pclk) clk_en <= 1'b0;
		pulse_pin(2);
		@(posedge pclk) clk_en <= 1'b1;
		idle(4);
		rd("timer frozen", IDX_TIMER, 32'h00);
	endtask

	task automatic t_irq();
		wr(IDX_IRQ, 8'h00);
		wr(IDX_IRQ, 8'h07);
		rd("no sw set", IDX_IRQ, 32'h0);
		@(posedge pclk) ext_int_n <= 1'b0;
		idle(6);
		rd("ext flag", IDX_IRQ, 32'h04);
		@(posedge pclk) port_b_in <= 8'h3D;
		idle(6);
		rd("port flag", IDX_IRQ, 32'h06);
		wr(IDX_MASK, 8'h02);
		rd("masked read", IDX_IRQ, 32'h02);
		wr(IDX_MASK, 8'h07);
		wr(IDX_IRQ, 8'h03);
		@(posedge pclk) ext_int_n <= 1'b1;
		idle(6);
		rd("rise ignored", IDX_IRQ, 32'h02);
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		t_reset();
		t_ram();
		t_status();
		t_ports();
		t_pc();
		t_stack();
		t_timer();
		t_irq();
		wrap_up();
	end
endmodule // tb_top
